// ===== hw/cfs_map.svh
// constants of the coherency filter sram module and its controller
// ****************************************************************
// Notes on behaviour
// - address, data, control common; own enables, scan
// - controller decodes; module adds no decode stage
// - one device at first position, or four
// - host gives two identical clocks, two sram loads each; first also clocks eeprom
// - first clock feeds positions one and three
// - read mode straps default high and low
// - both byte write enables held low
// - output enable and sleep inputs tied low
// - controller asserts one low enable per access
// - controller presents shared 18-bit word address
// - eeprom on i2c holds configuration data
// - upper address straps low, lowest follows select
// - host gives two modules distinct select levels
// - eeprom write protect held low permanently
// - scan chain through fitted devices, bypass gaps
// - scan enters first device, leaves fourth position
// ****************************************************************
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH

`define CFS_ADDR_W        18
`define CFS_DATA_W        18
`define CFS_POSITIONS     4
`define CFS_DEPTH         262144
`define CFS_READ_MODE_LOW  1'b1
`define CFS_READ_MODE_HIGH 1'b0
`define CFS_EE_FAMILY     4'hA
`define CFS_EE_STRAP_UP   1'b0
`define CFS_EE_STRAP_MID  1'b0
`define CFS_EE_BYTES      256
`define CFS_LINK_HALF     3'h4

`define CFS_REG_CTRL      8'h00
`define CFS_REG_ADDR      8'h04
`define CFS_REG_WDATA     8'h08
`define CFS_REG_RDATA     8'h0C
`define CFS_REG_STATUS    8'h10
`define CFS_REG_PINS      8'h14
`define CFS_CTRL_START    0
`define CFS_CTRL_WRITE    1
`define CFS_CTRL_POS_LO   2
`define CFS_CTRL_SELECT   4
`define CFS_CTRL_FOUR     5

`endif

// ===== hw/cfs_pkg.sv
// types shared by both ends of the coherency filter link
`include "cfs_map.svh"
package cfs_pkg;
  typedef logic [`CFS_ADDR_W-1:0] cfs_addr_t;
  typedef logic [`CFS_DATA_W-1:0] cfs_word_t;
  typedef enum logic [2:0] {
    CFS_H_IDLE = 3'b000,
    CFS_H_ACC  = 3'b001,
    CFS_H_HOLD = 3'b010,
    CFS_H_RD1  = 3'b011,
    CFS_H_RD2  = 3'b100
  } cfs_host_state_t;
  typedef enum logic [2:0] {
    CFS_I_IDLE  = 3'b000,
    CFS_I_DEV   = 3'b001,
    CFS_I_WORD  = 3'b010,
    CFS_I_WRITE = 3'b011,
    CFS_I_ACK   = 3'b100,
    CFS_I_READ  = 3'b101,
    CFS_I_MACK  = 3'b110
  } cfs_i2c_state_t;
endpackage

// ===== hw/cfs_link_if.sv
// edge connector between the controller and the memory module
`timescale 1ns/1ps
`default_nettype none
interface cfs_link_if;
  import cfs_pkg::*;
  logic [1:0]  sram_clk;
  logic [3:0]  chip_enable_n;
  cfs_addr_t   addr;
  logic        write_n;
  cfs_word_t   data_h_o;
  logic        data_h_oe;
  cfs_word_t   data_d_o;
  logic        data_d_oe;
  cfs_word_t   data;
  logic        scl_h_oe;
  logic        sda_h_oe;
  logic        sda_d_oe;
  logic        scl;
  logic        sda;
  logic        eeprom_addr_select;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo_d_oe;
  logic        tdo;
  logic        installed_n;
  // open-drain lines idle high through the host pull-ups
  assign data = data_d_oe ? data_d_o : (data_h_oe ? data_h_o : '0);
  assign scl  = ~scl_h_oe;
  assign sda  = ~(sda_h_oe | sda_d_oe);
  assign tdo  = ~tdo_d_oe;
  modport dev (input sram_clk, chip_enable_n, addr, write_n, data, scl, sda,
               eeprom_addr_select, tck, tms, tdi,
               output data_d_o, data_d_oe, sda_d_oe, tdo_d_oe, installed_n);
  modport host (input data, scl, sda, tdo, installed_n,
                output sram_clk, chip_enable_n, addr, write_n, data_h_o, data_h_oe,
                scl_h_oe, sda_h_oe, eeprom_addr_select, tck, tms, tdi);
endinterface
`default_nettype wire

// ===== hw/cfs_device.sv
// memory module: sram array, configuration eeprom and scan chain
//
// Chosen in the controller: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_map.svh"
module cfs_device #(
  parameter bit FOUR_FITTED = 1'b1
) (
  cfs_link_if.dev                link,
  input  wire logic              reset_n,
  output logic                   read_mode_strap_low,
  output logic                   read_mode_strap_high,
  output logic                   byte_write_lower_n,
  output logic                   byte_write_upper_n,
  output logic                   output_enable_n,
  output logic                   sleep_request,
  output logic                   eeprom_addr_strap_upper,
  output logic                   eeprom_addr_strap_middle,
  output logic                   eeprom_write_protect,
  output logic [3:0]             fitted
);
  import cfs_pkg::*;

  // ****************************************************************
  // static straps
  // ****************************************************************
  assign read_mode_strap_low      = `CFS_READ_MODE_LOW;
  assign read_mode_strap_high     = `CFS_READ_MODE_HIGH;
  assign byte_write_lower_n       = 1'b0;
  assign byte_write_upper_n       = 1'b0;
  assign output_enable_n          = 1'b0;
  assign sleep_request            = 1'b0;
  assign eeprom_addr_strap_upper  = `CFS_EE_STRAP_UP;
  assign eeprom_addr_strap_middle = `CFS_EE_STRAP_MID;
  assign eeprom_write_protect     = 1'b0;
  assign link.installed_n         = 1'b0;

  // ****************************************************************
  // sram positions
  // ****************************************************************
  cfs_word_t  pos_dout [`CFS_POSITIONS];
  logic [3:0] pos_oe;
  logic [3:0] chain;
  assign chain[0] = link.tdi;

  for (genvar p = 0; p < `CFS_POSITIONS; p++) begin : g_pos
    if (p == 0 || FOUR_FITTED) begin : g_fit
      // even positions run on the first clock, odd on the second
      wire        pclk = link.sram_clk[p % 2];
      cfs_word_t  mem [`CFS_DEPTH];
      logic       pend_ff;
      cfs_addr_t  raddr_ff;
      cfs_word_t  dout_ff;
      logic       oe_ff;
      logic       scan_ff;
      logic       take;
      logic       nxt_pend;
      cfs_addr_t  nxt_raddr;
      assign take = ~link.chip_enable_n[p];
      always_comb begin
        nxt_pend  = take & link.write_n;
        nxt_raddr = take ? link.addr : raddr_ff;
      end
      // global write covers the whole word; no byte lanes
      always_ff @(posedge pclk) begin
        if (take && !link.write_n) begin
          mem[link.addr] <= link.data;
        end
      end
      // register read mode: data follows the address by one edge
      always_ff @(posedge pclk or negedge reset_n) begin
        if (!reset_n) begin
          pend_ff  <= 1'b0;
          raddr_ff <= '0;
          dout_ff  <= '0;
          oe_ff    <= 1'b0;
        end else begin
          pend_ff  <= nxt_pend;
          raddr_ff <= nxt_raddr;
          dout_ff  <= pend_ff ? mem[raddr_ff] : dout_ff;
          oe_ff    <= pend_ff;
        end
      end
      always_ff @(posedge link.tck or negedge reset_n) begin
        if (!reset_n) begin
          scan_ff <= 1'b0;
        end else begin
          scan_ff <= chain[p];
        end
      end
      assign pos_dout[p] = dout_ff;
      assign pos_oe[p]   = oe_ff;
      assign fitted[p]   = 1'b1;
      if (p < `CFS_POSITIONS - 1) begin : g_link
        assign chain[p+1] = scan_ff;
      end else begin : g_last
        assign link.tdo_d_oe = ~scan_ff;
      end
    end else begin : g_empty
      assign pos_dout[p] = '0;
      assign pos_oe[p]   = 1'b0;
      assign fitted[p]   = 1'b0;
      // bypass link keeps the chain whole
      if (p < `CFS_POSITIONS - 1) begin : g_link
        assign chain[p+1] = chain[p];
      end else begin : g_last
        assign link.tdo_d_oe = ~chain[p];
      end
    end
  end

  // shared data bus: no decode here, the controller selects one device
  always_comb begin
    link.data_d_o = '0;
    for (int i = 0; i < `CFS_POSITIONS; i++) begin
      link.data_d_o = link.data_d_o | (pos_oe[i] ? pos_dout[i] : '0);
    end
  end
  assign link.data_d_oe = |pos_oe;

  // ****************************************************************
  // configuration eeprom on i2c
  // ****************************************************************
  // runs on the first host clock, which the controller keeps running
  wire             eclk = link.sram_clk[0];
  logic [2:0]      scl_ff;
  logic [2:0]      sda_ff;
  logic [1:0]      asel_ff;
  cfs_i2c_state_t  st_ff, nxt_st, ret_ff, nxt_ret;
  logic [3:0]      cnt_ff, nxt_cnt;
  logic [7:0]      sh_ff, nxt_sh;
  logic [7:0]      ptr_ff, nxt_ptr;
  logic            low_ff, nxt_low;
  logic            mack_ff, nxt_mack;
  logic            ee_we;
  logic [7:0]      ee_mem [`CFS_EE_BYTES];
  wire scl_rise = scl_ff[1] & ~scl_ff[2];
  wire scl_fall = ~scl_ff[1] & scl_ff[2];
  wire start    = scl_ff[1] & sda_ff[2] & ~sda_ff[1];
  wire stop     = scl_ff[1] & ~sda_ff[2] & sda_ff[1];
  wire [6:0] my_addr = {`CFS_EE_FAMILY, eeprom_addr_strap_upper,
                        eeprom_addr_strap_middle, asel_ff[1]};

  always_comb begin
    nxt_st   = st_ff;
    nxt_ret  = ret_ff;
    nxt_cnt  = cnt_ff;
    nxt_sh   = sh_ff;
    nxt_ptr  = ptr_ff;
    nxt_low  = low_ff;
    nxt_mack = mack_ff;
    ee_we    = 1'b0;
    if (start) begin
      nxt_st  = CFS_I_DEV;
      nxt_cnt = 4'h0;
      nxt_low = 1'b0;
    end else if (stop) begin
      nxt_st  = CFS_I_IDLE;
      nxt_low = 1'b0;
    end else begin
      case (st_ff)
        CFS_I_DEV, CFS_I_WORD, CFS_I_WRITE: begin
          if (scl_rise) begin
            nxt_sh  = {sh_ff[6:0], sda_ff[1]};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == 4'h8) begin
            nxt_low = 1'b1;
            nxt_st  = CFS_I_ACK;
            if (st_ff == CFS_I_DEV) begin
              nxt_ret = sh_ff[0] ? CFS_I_READ : CFS_I_WORD;
              if (sh_ff[7:1] != my_addr) begin
                nxt_low = 1'b0;
                nxt_st  = CFS_I_IDLE;
              end
            end else if (st_ff == CFS_I_WORD) begin
              nxt_ptr = sh_ff;
              nxt_ret = CFS_I_WRITE;
            end else begin
              ee_we   = 1'b1;
              nxt_ptr = ptr_ff + 8'h01;
              nxt_ret = CFS_I_WRITE;
            end
          end
        end
        CFS_I_ACK: begin
          if (scl_fall) begin
            nxt_cnt = 4'h0;
            nxt_st  = ret_ff;
            nxt_low = 1'b0;
            if (ret_ff == CFS_I_READ) begin
              nxt_low = ~ee_mem[ptr_ff][7];
              nxt_sh  = {ee_mem[ptr_ff][6:0], 1'b0};
              nxt_ptr = ptr_ff + 8'h01;
            end
          end
        end
        CFS_I_READ: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (cnt_ff == 4'h8) begin
              nxt_low = 1'b0;
              nxt_st  = CFS_I_MACK;
            end else begin
              nxt_low = ~sh_ff[7];
              nxt_sh  = {sh_ff[6:0], 1'b0};
            end
          end
        end
        CFS_I_MACK: begin
          if (scl_rise) begin
            nxt_mack = ~sda_ff[1];
          end else if (scl_fall) begin
            nxt_cnt = 4'h0;
            nxt_st  = mack_ff ? CFS_I_READ : CFS_I_IDLE;
            if (mack_ff) begin
              nxt_low = ~ee_mem[ptr_ff][7];
              nxt_sh  = {ee_mem[ptr_ff][6:0], 1'b0};
              nxt_ptr = ptr_ff + 8'h01;
            end
          end
        end
        default: begin
          nxt_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge eclk) begin
    if (ee_we) begin
      ee_mem[ptr_ff] <= sh_ff;
    end
  end

  always_ff @(posedge eclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_ff  <= 3'h7;
      sda_ff  <= 3'h7;
      asel_ff <= 2'h0;
      st_ff   <= CFS_I_IDLE;
      ret_ff  <= CFS_I_IDLE;
      cnt_ff  <= 4'h0;
      sh_ff   <= 8'h00;
      ptr_ff  <= 8'h00;
      low_ff  <= 1'b0;
      mack_ff <= 1'b0;
    end else begin
      scl_ff  <= {scl_ff[1:0], link.scl};
      sda_ff  <= {sda_ff[1:0], link.sda};
      asel_ff <= {asel_ff[0], link.eeprom_addr_select};
      st_ff   <= nxt_st;
      ret_ff  <= nxt_ret;
      cnt_ff  <= nxt_cnt;
      sh_ff   <= nxt_sh;
      ptr_ff  <= nxt_ptr;
      low_ff  <= nxt_low;
      mack_ff <= nxt_mack;
    end
  end
  assign link.sda_d_oe = low_ff;
endmodule
`default_nettype wire

// ===== hw/cfs_host.sv
// chipset controller end: ahb-lite registers driving the module
`timescale 1ns/1ps
`default_nettype none
`include "cfs_map.svh"
module cfs_host (
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  cfs_link_if.host           link
);
  import cfs_pkg::*;

  // ****************************************************************
  // register bus
  // ****************************************************************
  logic            wr_ph_ff;
  logic [7:0]      wa_ff;
  logic [31:0]     rd_ff;
  logic            start_ff, wr_ff, sel_ff, four_ff;
  logic [1:0]      pos_ff;
  cfs_addr_t       addr_ff;
  cfs_word_t       wdata_ff, rdata_ff;
  logic [4:0]      pins_ff;
  logic            done_ff;
  logic [2:0]      div_ff;
  logic            clk_ff;
  cfs_host_state_t st_ff, nxt_st;
  logic [3:0]      ce_n_ff, nxt_ce_n;
  logic            we_n_ff, nxt_we_n, doe_ff, nxt_doe;
  cfs_word_t       nxt_rdata;
  logic            nxt_done, nxt_start;
  logic [1:0]      inst_s, scl_s, sda_s, tdo_s;
  cfs_word_t       dat_s1, dat_s2;

  function automatic logic [31:0] read_reg(input logic [7:0] a);
    case (a)
      `CFS_REG_CTRL:   read_reg = {26'h0, four_ff, sel_ff, pos_ff, wr_ff, start_ff};
      `CFS_REG_ADDR:   read_reg = {14'h0, addr_ff};
      `CFS_REG_WDATA:  read_reg = {14'h0, wdata_ff};
      `CFS_REG_RDATA:  read_reg = {14'h0, rdata_ff};
      `CFS_REG_STATUS: read_reg = {26'h0, tdo_s[1], sda_s[1], scl_s[1], ~inst_s[1],
                                   done_ff, (st_ff != CFS_H_IDLE) | start_ff};
      `CFS_REG_PINS:   read_reg = {27'h0, pins_ff};
      default:         read_reg = 32'h0;
    endcase
  endfunction

  wire take    = hsel & hready & htrans[1];
  wire rise    = (div_ff == `CFS_LINK_HALF - 3'h1) & ~clk_ff;
  wire fall    = (div_ff == `CFS_LINK_HALF - 3'h1) & clk_ff;
  wire ctrl_wr = wr_ph_ff & (wa_ff == `CFS_REG_CTRL);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rd_ff;

  // ****************************************************************
  // access sequencer, stepped on link clock phases
  // ****************************************************************
  always_comb begin
    nxt_st    = st_ff;
    nxt_ce_n  = ce_n_ff;
    nxt_we_n  = we_n_ff;
    nxt_doe   = doe_ff;
    nxt_rdata = rdata_ff;
    nxt_done  = done_ff;
    nxt_start = start_ff;
    if (ctrl_wr && hwdata[`CFS_CTRL_START]) begin
      nxt_done = 1'b0;
    end
    case (st_ff)
      CFS_H_IDLE: begin
        // changes land on the falling phase to meet setup at the rise
        if (start_ff && fall) begin
          nxt_start = 1'b0;
          nxt_ce_n  = 4'hF;
          nxt_ce_n[four_ff ? pos_ff : 2'h0] = 1'b0;
          nxt_we_n  = ~wr_ff;
          nxt_doe   = wr_ff;
          nxt_st    = CFS_H_ACC;
        end
      end
      CFS_H_ACC: begin
        if (rise) begin
          nxt_st = CFS_H_HOLD;
        end
      end
      CFS_H_HOLD: begin
        if (fall) begin
          nxt_ce_n = 4'hF;
          nxt_we_n = 1'b1;
          nxt_doe  = 1'b0;
          nxt_st   = we_n_ff ? CFS_H_RD1 : CFS_H_IDLE;
          nxt_done = ~we_n_ff ? 1'b1 : done_ff;
        end
      end
      CFS_H_RD1: begin
        if (rise) begin
          nxt_st = CFS_H_RD2;
        end
      end
      CFS_H_RD2: begin
        if (fall) begin
          nxt_rdata = dat_s2;
          nxt_done  = 1'b1;
          nxt_st    = CFS_H_IDLE;
        end
      end
      default: begin
        nxt_st = CFS_H_IDLE;
      end
    endcase
    // a new start beats the one being consumed, so none is lost
    if (ctrl_wr && hwdata[`CFS_CTRL_START]) begin
      nxt_start = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ph_ff <= 1'b0;
      wa_ff    <= 8'h00;
      rd_ff    <= 32'h0;
      start_ff <= 1'b0;
      wr_ff    <= 1'b0;
      sel_ff   <= 1'b0;
      four_ff  <= 1'b0;
      pos_ff   <= 2'h0;
      addr_ff  <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      pins_ff  <= 5'h00;
      done_ff  <= 1'b0;
      div_ff   <= 3'h0;
      clk_ff   <= 1'b0;
      st_ff    <= CFS_H_IDLE;
      ce_n_ff  <= 4'hF;
      we_n_ff  <= 1'b1;
      doe_ff   <= 1'b0;
      inst_s   <= 2'h3;
      scl_s    <= 2'h3;
      sda_s    <= 2'h3;
      tdo_s    <= 2'h3;
      dat_s1   <= '0;
      dat_s2   <= '0;
    end else begin
      wr_ph_ff <= take & hwrite;
      wa_ff    <= take ? haddr[7:0] : wa_ff;
      rd_ff    <= (take && !hwrite) ? read_reg(haddr[7:0]) : rd_ff;
      if (ctrl_wr) begin
        wr_ff   <= hwdata[`CFS_CTRL_WRITE];
        pos_ff  <= hwdata[`CFS_CTRL_POS_LO +: 2];
        sel_ff  <= hwdata[`CFS_CTRL_SELECT];
        four_ff <= hwdata[`CFS_CTRL_FOUR];
      end
      if (wr_ph_ff && wa_ff == `CFS_REG_ADDR) begin
        addr_ff <= hwdata[`CFS_ADDR_W-1:0];
      end
      if (wr_ph_ff && wa_ff == `CFS_REG_WDATA) begin
        wdata_ff <= hwdata[`CFS_DATA_W-1:0];
      end
      if (wr_ph_ff && wa_ff == `CFS_REG_PINS) begin
        pins_ff <= hwdata[4:0];
      end
      start_ff <= nxt_start;
      done_ff  <= nxt_done;
      rdata_ff <= nxt_rdata;
      div_ff   <= (div_ff == `CFS_LINK_HALF - 3'h1) ? 3'h0 : div_ff + 3'h1;
      clk_ff   <= (div_ff == `CFS_LINK_HALF - 3'h1) ? ~clk_ff : clk_ff;
      st_ff    <= nxt_st;
      ce_n_ff  <= nxt_ce_n;
      we_n_ff  <= nxt_we_n;
      doe_ff   <= nxt_doe;
      inst_s   <= {inst_s[0], link.installed_n};
      scl_s    <= {scl_s[0], link.scl};
      sda_s    <= {sda_s[0], link.sda};
      tdo_s    <= {tdo_s[0], link.tdo};
      dat_s1   <= link.data;
      dat_s2   <= dat_s1;
    end
  end

  // ****************************************************************
  // link pins
  // ****************************************************************
  assign link.sram_clk           = {clk_ff, clk_ff};
  assign link.chip_enable_n      = ce_n_ff;
  assign link.addr               = addr_ff;
  assign link.write_n            = we_n_ff;
  assign link.data_h_o           = wdata_ff;
  assign link.data_h_oe          = doe_ff;
  assign link.eeprom_addr_select = sel_ff;
  assign link.scl_h_oe           = pins_ff[0];
  assign link.sda_h_oe           = pins_ff[1];
  assign link.tck                = pins_ff[2];
  assign link.tms                = pins_ff[3];
  assign link.tdi                = pins_ff[4];
endmodule
`default_nettype wire

// ===== sim/cfs_link_asserts.sv
// assertions watching the edge connector between controller and module
`timescale 1ns/1ps
`default_nettype none
module cfs_link_asserts (
  input wire logic [1:0] sram_clk,
  input wire logic [3:0] chip_enable_n,
  input wire logic       write_n,
  input wire logic       data_h_oe,
  input wire logic       data_d_oe,
  input wire logic       scl,
  input wire logic       sda_d_oe,
  input wire logic       reset_n
);
  default clocking cb @(posedge sram_clk[0]); endclocking
  default disable iff (!reset_n);
  property p_one_ce;
    $onehot0(~chip_enable_n);
  endproperty
  a_one_ce: assert property (p_one_ce)
    else $error("more than one chip enable low");
  property p_ce_stand;
    chip_enable_n != 4'hF |=> chip_enable_n == 4'hF;
  endproperty
  a_ce_stand: assert property (p_ce_stand)
    else $error("chip enable held past one link period");
  property p_rd_answer;
    chip_enable_n != 4'hF && write_n |-> ##[1:2] data_d_oe;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("no read data after a selected read");
  property p_rd_stand;
    data_d_oe |=> !data_d_oe;
  endproperty
  a_rd_stand: assert property (p_rd_stand)
    else $error("read data driven longer than one period");
  property p_quiet_on_ce;
    chip_enable_n != 4'hF |-> !data_d_oe;
  endproperty
  a_quiet_on_ce: assert property (p_quiet_on_ce)
    else $error("module drives data while controller selects");
  property p_we_drive;
    data_h_oe == !write_n;
  endproperty
  a_we_drive: assert property (p_we_drive)
    else $error("write data drive does not match write enable");
  property p_no_clash;
    !(data_h_oe && data_d_oe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data bus");
  property p_sda_timing;
    $rose(sda_d_oe) |-> !scl;
  endproperty
  a_sda_timing: assert property (p_sda_timing)
    else $error("eeprom changed sda while scl high");
endmodule
`default_nettype wire

// ===== sim/tb_coherency_filter_sram_module.sv
// self-checking bench joining the controller and the memory module
`timescale 1ns/1ps
`default_nettype none
module tb_coherency_filter_sram_module;
  import cfs_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_h_n = 1'b0;
  logic        rst_d_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [8:0]  straps;
  logic [3:0]  fitted;
  logic [31:0] rd;
  logic [31:0] wv [4];
  logic [17:0] a0;
  logic [3:0]  hist = '0;
  logic [7:0]  ew;
  logic [7:0]  ed;
  logic [7:0]  r8;
  logic        ack;
  logic        b;
  logic        sel = 1'b0;
  int          n_fail = 0;
  int          n_checks = 0;
  int          seed = 32'hE38B15E7;
  cfs_link_if i_cfs_link_if ();
  assign hready = hreadyout;
  cfs_host i_cfs_host (.ref_clk(ref_clk), .reset_n(rst_h_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(i_cfs_link_if));
  cfs_device #(.FOUR_FITTED(1'b1)) i_cfs_device (.link(i_cfs_link_if), .reset_n(rst_d_n),
    .read_mode_strap_low(straps[8]), .read_mode_strap_high(straps[7]),
    .byte_write_lower_n(straps[6]), .byte_write_upper_n(straps[5]),
    .output_enable_n(straps[4]), .sleep_request(straps[3]),
    .eeprom_addr_strap_upper(straps[2]), .eeprom_addr_strap_middle(straps[1]),
    .eeprom_write_protect(straps[0]), .fitted(fitted));
  cfs_link_asserts i_cfs_link_asserts (.sram_clk(i_cfs_link_if.sram_clk),
    .chip_enable_n(i_cfs_link_if.chip_enable_n), .write_n(i_cfs_link_if.write_n),
    .data_h_oe(i_cfs_link_if.data_h_oe), .data_d_oe(i_cfs_link_if.data_d_oe),
    .scl(i_cfs_link_if.scl), .sda_d_oe(i_cfs_link_if.sda_d_oe), .reset_n(rst_d_n));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // ****************************************************************
  // bus and pin tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic hwait();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    tmo(k, 64);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hwait();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    hwait();
    r = hrdata;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  function automatic logic [31:0] f_ctrl(logic st, logic wr, logic [1:0] p, logic four);
    return {26'h0, four, sel, p, wr, st};
  endfunction
  // eeprom address: fixed family, upper straps low, select as lowest bit
  function automatic logic [7:0] f_dev(logic rnw);
    return {4'hA, 2'h0, sel, rnw};
  endfunction
  task automatic acc(input logic wr, input logic [1:0] p, input logic four,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    wreg(8'h04, {14'h0, a0});
    wreg(8'h08, d);
    wreg(8'h00, f_ctrl(1'b1, wr, p, four));
    k = 0;
    do begin
      ahb(1'b0, 8'h10, '0, r);
      k++;
    end while (r[1] !== 1'b1 && k < 50);
    tmo(k, 50);
    ahb(1'b0, 8'h0C, '0, r);
  endtask
  // slow bit-banging: the eeprom sees scl through two link clock flops
  task automatic pins(input logic c, input logic d, input logic t, input logic i);
    wreg(8'h14, {27'h0, i, 1'b0, t, ~d, ~c});
    repeat (40) @(posedge ref_clk);
  endtask
  task automatic ibit(input logic bi, output logic r);
    logic [31:0] s;
    pins(1'b0, bi, 1'b0, 1'b0);
    pins(1'b1, bi, 1'b0, 1'b0);
    ahb(1'b0, 8'h10, '0, s);
    r = s[4];
    pins(1'b0, bi, 1'b0, 1'b0);
  endtask
  task automatic ibyte(input logic [7:0] v, input logic mack, output logic [7:0] r,
                       output logic a);
    for (int i = 7; i >= 0; i--) begin
      ibit(v[i], r[i]);
    end
    ibit(mack, a);
  endtask
  task automatic isend(input logic [7:0] v, input logic nack_exp);
    ibyte(v, 1'b1, r8, ack);
    chk(ack, nack_exp);
  endtask
  task automatic istart();
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic istop();
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_h_n <= 1'b1;
    // device reset lets go between link clock edges
    repeat (22) @(posedge ref_clk);
    rst_d_n <= 1'b1;
    chk(straps, 9'h100);
    chk(fitted, 4'hF);
    repeat (24) begin
      @(negedge ref_clk);
      chk(i_cfs_link_if.sram_clk[1], i_cfs_link_if.sram_clk[0]);
    end
    ahb(1'b0, 8'h20, '0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h10, '0, rd);
    chk(rd[2], 1'b1);
    chk(hresp, 1'b0);
    $display("test statics done");
    a0 = 18'($random(seed));
    for (int i = 0; i < 4; i++) begin
      wv[i] = $random(seed);
      acc(1'b1, 2'(i), 1'b1, wv[i], rd);
    end
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 2'(i), 1'b1, '0, rd);
      chk(rd, {14'h0, wv[i][17:0]});
    end
    acc(1'b1, 2'h3, 1'b0, 32'hFFFFFFFF, rd);
    acc(1'b0, 2'h0, 1'b1, '0, rd);
    chk(rd, 32'h3FFFF);
    acc(1'b0, 2'h3, 1'b1, '0, rd);
    chk(rd, {14'h0, wv[3][17:0]});
    $display("test sram done");
    for (int i = 0; i < 8; i++) begin
      b = 1'($random(seed));
      hist = {hist[2:0], b};
      pins(1'b1, 1'b1, 1'b0, b);
      pins(1'b1, 1'b1, 1'b1, b);
      ahb(1'b0, 8'h10, '0, rd);
      chk(rd[5], hist[3]);
    end
    $display("test scan chain done");
    sel = 1'b1;
    wreg(8'h00, f_ctrl(1'b0, 1'b0, 2'h0, 1'b1));
    @(negedge ref_clk);
    chk(i_cfs_link_if.eeprom_addr_select, 1'b1);
    ew = 8'($random(seed));
    ed = 8'($random(seed));
    istart();
    isend(f_dev(1'b0), 1'b0);
    isend(ew, 1'b0);
    isend(ed, 1'b0);
    istop();
    istart();
    isend(f_dev(1'b0), 1'b0);
    isend(ew, 1'b0);
    istart();
    isend(f_dev(1'b1), 1'b0);
    ibyte(8'hFF, 1'b1, r8, ack);
    chk(r8, ed);
    istop();
    istart();
    isend({4'hA, 4'h0}, 1'b1);
    istop();
    $display("test eeprom done");
    print_verdict();
  end
endmodule
`default_nettype wire
